// ===== hw/rqh_requester_host.sv
// The address map and the AXI4-Lite slave port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module rqh_requester_host
    import rqh_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic [63:0] req_in_data,
    output logic req_in_valid,
    input wire logic req_in_ready,
    output logic req_in_last,
    output logic [1:0] req_in_dword_keep,
    output rqh_side_t req_in_sideband,
    input wire logic [7:0] alloc_tag_out,
    input wire logic alloc_tag_strobe
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        rqh_state_t st;
        rqh_beat_t beat;
        rqh_side_t side;
        logic valid;
        logic [LEN_W-1:0] idx;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [CTRL_W-1:0] ctrl;
        logic [3:0][31:0] desc;
        logic [LEN_W-1:0] paylen;
        logic [MASKS_W-1:0] masks;
        logic [31:0] seed;
        logic [LEN_W-1:0] abort_beat;
        rqh_kind_t kind;
        logic aligned;
        logic zero_len;
        logic abort_en;
        logic off;
        logic [LEN_W:0] span;
        logic [7:0] tag_last;
        logic [15:0] tag_cnt;
    } rqh_regs_t;

    rqh_regs_t r_reg, r_next;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] v;
        v = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                v[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return v;
    endfunction

    // Payload beat k: offset lanes are null but kept, words count up from seed
    function automatic rqh_beat_t mk_beat(input logic [LEN_W-1:0] k, input logic [LEN_W:0] span,
                                          input logic off, input logic [31:0] seed, input logic hit);
        rqh_beat_t b;
        logic [LEN_W:0] pos;
        b = '0;
        pos = '0;
        for (int i = 0; i < 2; i++) begin
            pos = {k, 1'b0} + (LEN_W+1)'(i);
            b.keep[i] = (pos < span);
            if (pos < span && pos >= (LEN_W+1)'(off)) begin
                b.data[i*32 +: 32] = seed + 32'(pos - (LEN_W+1)'(off));
            end
        end
        b.last = (({k, 1'b0} + (LEN_W+1)'(2)) >= span) || hit;
        b.disc = hit;
        return b;
    endfunction

    always_comb begin
        r_next = r_reg;
        // ----------------------------------------
        // Register bus write
        // ----------------------------------------
        r_next.awready = 1'b0;
        r_next.wready = 1'b0;
        if (r_reg.bvalid && bready) begin
            r_next.bvalid = 1'b0;
        end
        if (awvalid && wvalid && !r_reg.awready && !r_reg.bvalid) begin
            r_next.awready = 1'b1;
            r_next.wready = 1'b1;
            r_next.bvalid = 1'b1;
            r_next.bresp = RESP_OKAY;
            unique case (awaddr)
                ADDR_CTRL: begin
                    if (wstrb[0]) begin
                        r_next.ctrl = wdata[CTRL_W-1:0];
                    end
                end
                ADDR_DESC0: r_next.desc[0] = merge(r_reg.desc[0], wdata, wstrb);
                ADDR_DESC1: r_next.desc[1] = merge(r_reg.desc[1], wdata, wstrb);
                ADDR_DESC2: r_next.desc[2] = merge(r_reg.desc[2], wdata, wstrb);
                ADDR_DESC3: r_next.desc[3] = merge(r_reg.desc[3], wdata, wstrb);
                ADDR_PAYLEN: r_next.paylen = LEN_W'(merge(32'(r_reg.paylen), wdata, wstrb));
                ADDR_MASKS: r_next.masks = MASKS_W'(merge(32'(r_reg.masks), wdata, wstrb));
                ADDR_SEED: r_next.seed = merge(r_reg.seed, wdata, wstrb);
                ADDR_ABORT: r_next.abort_beat = LEN_W'(merge(32'(r_reg.abort_beat), wdata, wstrb));
                default: r_next.bresp = RESP_SLVERR;
            endcase
            // Start only from idle; a go while busy is dropped
            if (awaddr == ADDR_CTRL && wstrb[0] && wdata[CTRL_GO] && r_reg.st == ST_IDLE) begin
                r_next.kind = rqh_kind_t'(wdata[CTRL_KIND_LO +: 2]);
                r_next.aligned = wdata[CTRL_ALIGNED];
                r_next.zero_len = wdata[CTRL_ZERO_LEN];
                r_next.abort_en = wdata[CTRL_ABORT_EN];
                r_next.st = ST_DESC0;
                r_next.valid = 1'b1;
                r_next.idx = '0;
                // Descriptor words, tag included, come from software as written
                r_next.beat = '{data: {r_reg.desc[1], r_reg.desc[0]}, keep: 2'h3, last: 1'b0, disc: 1'b0};
                r_next.side = '0;
                r_next.side.first_mask = r_reg.masks[3:0];
                r_next.side.last_mask = r_reg.masks[7:4];
                r_next.side.start_lane = r_reg.masks[10:8];
                r_next.off = wdata[CTRL_ALIGNED] & r_reg.masks[8];
                r_next.span = (LEN_W+1)'(r_reg.paylen) + (LEN_W+1)'(r_next.off);
                unique case (rqh_kind_t'(wdata[CTRL_KIND_LO +: 2]))
                    KIND_READ: begin
                        r_next.span = '0;
                        if (wdata[CTRL_ZERO_LEN]) begin
                            r_next.side.first_mask = '0;
                            r_next.side.last_mask = '0;
                        end
                    end
                    KIND_NPW: r_next.side.last_mask = '0;
                    KIND_MSG: begin
                        r_next.side.first_mask = '0;
                        r_next.side.last_mask = '0;
                        r_next.side.start_lane = '0;
                        r_next.off = 1'b0;
                        r_next.span = (LEN_W+1)'(r_reg.paylen);
                    end
                    KIND_ATOM: begin
                        r_next.side.first_mask = MASK_ALL;
                        r_next.side.last_mask = MASK_ALL;
                    end
                endcase
            end
        end
        // ----------------------------------------
        // Register bus read
        // ----------------------------------------
        r_next.arready = 1'b0;
        if (r_reg.rvalid && rready) begin
            r_next.rvalid = 1'b0;
        end
        if (arvalid && !r_reg.arready && !r_reg.rvalid) begin
            r_next.arready = 1'b1;
            r_next.rvalid = 1'b1;
            r_next.rresp = RESP_OKAY;
            r_next.rdata = '0;
            unique case (araddr)
                ADDR_CTRL: r_next.rdata = 32'(r_reg.ctrl);
                ADDR_DESC0: r_next.rdata = r_reg.desc[0];
                ADDR_DESC1: r_next.rdata = r_reg.desc[1];
                ADDR_DESC2: r_next.rdata = r_reg.desc[2];
                ADDR_DESC3: r_next.rdata = r_reg.desc[3];
                ADDR_PAYLEN: r_next.rdata = 32'(r_reg.paylen);
                ADDR_MASKS: r_next.rdata = 32'(r_reg.masks);
                ADDR_SEED: r_next.rdata = r_reg.seed;
                ADDR_ABORT: r_next.rdata = 32'(r_reg.abort_beat);
                ADDR_STATUS: r_next.rdata = {r_reg.tag_cnt, r_reg.tag_last, 7'h00, r_reg.st != ST_IDLE};
                default: r_next.rresp = RESP_SLVERR;
            endcase
        end
        // ----------------------------------------
        // Request stream; nothing moves until ready
        // ----------------------------------------
        if (r_reg.valid && req_in_ready) begin
            unique case (r_reg.st)
                ST_DESC0: begin
                    r_next.st = ST_DESC1;
                    r_next.beat.data = {r_reg.desc[3], r_reg.desc[2]};
                    r_next.beat.last = (r_reg.span == '0);
                end
                ST_DESC1, ST_PAY: begin
                    if (r_reg.beat.last) begin
                        r_next.st = ST_IDLE;
                        r_next.valid = 1'b0;
                        r_next.beat = '0;
                        r_next.side = '0;
                    end else begin
                        r_next.st = ST_PAY;
                        r_next.idx = (r_reg.st == ST_PAY) ? r_reg.idx + LEN_W'(1) : '0;
                        // Dword-aligned payload starts at lane 0 right after descriptor
                        r_next.beat = mk_beat(r_next.idx, r_reg.span, r_reg.off, r_reg.seed,
                                              r_reg.abort_en && r_next.idx == r_reg.abort_beat);
                        r_next.side.discontinue = r_next.beat.disc;
                    end
                end
                default: r_next.st = r_reg.st;
            endcase
        end
        // ----------------------------------------
        // Tag capture
        // ----------------------------------------
        if (alloc_tag_strobe) begin
            r_next.tag_last = alloc_tag_out;
            r_next.tag_cnt = r_reg.tag_cnt + 16'h0001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_reg <= '0;
            r_reg.st <= ST_IDLE;
        end else begin
            r_reg <= r_next;
        end
    end

    assign awready = r_reg.awready;
    assign wready = r_reg.wready;
    assign bvalid = r_reg.bvalid;
    assign bresp = r_reg.bresp;
    assign arready = r_reg.arready;
    assign rvalid = r_reg.rvalid;
    assign rresp = r_reg.rresp;
    assign rdata = r_reg.rdata;
    assign req_in_data = r_reg.beat.data;
    assign req_in_valid = r_reg.valid;
    assign req_in_last = r_reg.beat.last;
    assign req_in_dword_keep = r_reg.beat.keep;
    assign req_in_sideband = r_reg.side;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_hold;
        req_in_valid && !req_in_ready |=> req_in_valid && $stable(req_in_data) && $stable(req_in_sideband)
            && $stable(req_in_last) && $stable(req_in_dword_keep);
    endproperty
    a_hold: assert property (p_hold) else $error("request changed while stalled");

    property p_valid_whole;
        req_in_valid && !req_in_last |=> req_in_valid;
    endproperty
    a_valid_whole: assert property (p_valid_whole) else $error("valid dropped inside packet");

    property p_desc_keep;
        (r_reg.st == ST_DESC0 || r_reg.st == ST_DESC1) |-> req_in_valid && req_in_dword_keep == 2'h3;
    endproperty
    a_desc_keep: assert property (p_desc_keep) else $error("descriptor lanes not kept");

    property p_msg_pay;
        r_reg.st == ST_DESC1 && req_in_ready && r_reg.kind == KIND_MSG && !req_in_last |=> r_reg.st == ST_PAY
            && req_in_data[31:0] == r_reg.seed && req_in_dword_keep[0];
    endproperty
    a_msg_pay: assert property (p_msg_pay) else $error("message payload not right after descriptor");
    property p_desc_pair;
        r_reg.st == ST_DESC0 && req_in_ready |=> r_reg.st == ST_DESC1 && req_in_data == {r_reg.desc[3], r_reg.desc[2]};
    endproperty
    a_desc_pair: assert property (p_desc_pair) else $error("descriptor not in two beats");

    property p_read_only_desc;
        r_reg.st == ST_DESC1 && r_reg.kind == KIND_READ |-> req_in_last && req_in_dword_keep == 2'h3;
    endproperty
    a_read_only_desc: assert property (p_read_only_desc) else $error("read carries data beats");

    property p_zero_len;
        req_in_valid && r_reg.kind == KIND_READ && r_reg.zero_len |-> req_in_sideband.first_mask == 4'h0
            && req_in_sideband.last_mask == 4'h0;
    endproperty
    a_zero_len: assert property (p_zero_len) else $error("zero-length read masks set");

    property p_atomic;
        req_in_valid && r_reg.kind == KIND_ATOM |-> req_in_sideband.first_mask == MASK_ALL
            && req_in_sideband.last_mask == MASK_ALL;
    endproperty
    a_atomic: assert property (p_atomic) else $error("atomic masks not full");

    property p_msg_lane;
        req_in_valid && r_reg.kind == KIND_MSG && r_reg.aligned |-> req_in_sideband.start_lane == 3'h0;
    endproperty
    a_msg_lane: assert property (p_msg_lane) else $error("message start lane not zero");

    property p_dw_align;
        r_reg.st == ST_DESC1 && req_in_ready && !req_in_last && !r_reg.aligned |=> req_in_data[31:0] == r_reg.seed;
    endproperty
    a_dw_align: assert property (p_dw_align) else $error("payload gap after descriptor");

    property p_addr_align;
        r_reg.st == ST_DESC1 && req_in_ready && !req_in_last && r_reg.off |=> req_in_data[63:32] == r_reg.seed
            && req_in_dword_keep == 2'h3;
    endproperty
    a_addr_align: assert property (p_addr_align) else $error("payload not at start lane");

    property p_disc;
        req_in_sideband.discontinue |-> req_in_valid && req_in_last && r_reg.st == ST_PAY;
    endproperty
    a_disc: assert property (p_disc) else $error("discontinue outside payload end");

    c_read: cover property (r_reg.st == ST_DESC1 && req_in_ready && r_reg.kind == KIND_READ);
    c_payload: cover property (r_reg.st == ST_PAY && req_in_ready && req_in_last && !req_in_sideband.discontinue);
    c_abort: cover property (req_in_sideband.discontinue && req_in_ready);
    c_tag: cover property (alloc_tag_strobe);
endmodule
`default_nettype wire

// ===== hw/rqh_pkg.sv
`default_nettype none
package rqh_pkg;
    // ----------------------------------------
    // Register map (byte offsets)
    // ----------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_DESC0 = 8'h04;
    localparam logic [7:0] ADDR_DESC1 = 8'h08;
    localparam logic [7:0] ADDR_DESC2 = 8'h0C;
    localparam logic [7:0] ADDR_DESC3 = 8'h10;
    localparam logic [7:0] ADDR_PAYLEN = 8'h14;
    localparam logic [7:0] ADDR_MASKS = 8'h18;
    localparam logic [7:0] ADDR_SEED = 8'h1C;
    localparam logic [7:0] ADDR_ABORT = 8'h20;
    localparam logic [7:0] ADDR_STATUS = 8'h24;
    // ----------------------------------------
    // Field positions, widths and codes
    // ----------------------------------------
    localparam int CTRL_GO = 0;
    localparam int CTRL_ALIGNED = 1;
    localparam int CTRL_KIND_LO = 2;
    localparam int CTRL_ZERO_LEN = 4;
    localparam int CTRL_ABORT_EN = 5;
    localparam int CTRL_W = 6;
    localparam int LEN_W = 10;
    localparam int MASKS_W = 11;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [3:0] MASK_ALL = 4'hF;
    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {
        KIND_READ = 2'h0,
        KIND_NPW = 2'h1,
        KIND_MSG = 2'h2,
        KIND_ATOM = 2'h3
    } rqh_kind_t;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_DESC0 = 4'b0010,
        ST_DESC1 = 4'b0100,
        ST_PAY = 4'b1000
    } rqh_state_t;
    typedef struct packed {
        logic discontinue;
        logic [2:0] start_lane;
        logic [3:0] last_mask;
        logic [3:0] first_mask;
    } rqh_side_t;
    typedef struct packed {
        logic [63:0] data;
        logic [1:0] keep;
        logic last;
        logic disc;
    } rqh_beat_t;
endpackage
`default_nettype wire

// ===== sim/rqh_dev_model.sv
`timescale 1ns/10ps
`default_nettype none
module rqh_dev_model
    import rqh_pkg::*;
#(
    parameter int LIMIT = 2,
    parameter int TAG_DELAY = 3
)(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [63:0] req_in_data,
    input wire logic req_in_valid,
    output logic req_in_ready,
    input wire logic req_in_last,
    input wire logic [1:0] req_in_dword_keep,
    input wire rqh_side_t req_in_sideband,
    output logic [7:0] alloc_tag_out,
    output logic alloc_tag_strobe,
    input wire logic slow,
    input wire logic posted,
    input wire logic free_one
);
    rqh_beat_t cap [16];
    rqh_side_t cap_side [16];
    int beat_n, cap_n, npkt, outst, pend, timer, hold_err, int_err;
    logic sticky, nulled, phase, stall_prev, np_done;
    logic [7:0] next_tag;
    logic [79:0] prev;
    // ----------------------------------------
    // Intake, stalls and tag issue
    // ----------------------------------------
    assign req_in_ready = aresetn && !(slow && phase) && !(beat_n == 0 && outst >= LIMIT);
    assign np_done = req_in_valid && req_in_ready && req_in_last && !posted;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            beat_n <= 0;
            npkt <= 0;
            outst <= 0;
            pend <= 0;
            timer <= 0;
            hold_err <= 0;
            int_err <= 0;
            sticky <= 1'b0;
            phase <= 1'b0;
            stall_prev <= 1'b0;
            next_tag <= 8'h00;
            alloc_tag_out <= 8'h00;
            alloc_tag_strobe <= 1'b0;
        end else begin
            phase <= !phase;
            stall_prev <= req_in_valid && !req_in_ready;
            prev <= {req_in_valid, req_in_data, req_in_last, req_in_dword_keep, req_in_sideband};
            if (stall_prev && prev !== {req_in_valid, req_in_data, req_in_last, req_in_dword_keep, req_in_sideband})
                hold_err <= hold_err + 1;
            if (beat_n > 0 && !req_in_valid)
                hold_err <= hold_err + 1;
            if (req_in_valid && req_in_ready) begin
                cap[beat_n] <= {req_in_data, req_in_dword_keep, req_in_last, req_in_sideband.discontinue};
                cap_side[beat_n] <= req_in_sideband;
                beat_n <= req_in_last ? 0 : beat_n + 1;
                sticky <= !req_in_last && (sticky || req_in_sideband.discontinue);
                if (req_in_last) begin
                    cap_n <= beat_n + 1;
                    npkt <= npkt + 1;
                    nulled <= sticky || req_in_sideband.discontinue;
                    if (sticky || req_in_sideband.discontinue) int_err <= int_err + 1;
                end
            end
            outst <= outst + int'(np_done) - int'(free_one);
            alloc_tag_strobe <= 1'b0;
            alloc_tag_out <= ~alloc_tag_out;
            if (pend > 0 && timer == TAG_DELAY) begin
                alloc_tag_strobe <= 1'b1;
                alloc_tag_out <= next_tag;
                next_tag <= next_tag + 8'h01;
                timer <= 0;
                pend <= pend + int'(np_done) - 1;
            end else begin
                timer <= pend > 0 ? timer + 1 : 0;
                pend <= pend + int'(np_done);
            end
        end
    end
endmodule
`default_nettype wire

// ===== sim/test_requester_request_port.sv
`timescale 1ns/10ps
`default_nettype none
module test_requester_request_port
    import rqh_pkg::*;
;
    localparam logic [31:0] SEED_V = 32'hA000_0000;
    logic aclk = '0, aresetn = '0;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = '0;
    logic awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
    logic slow = '0, posted = '0, free_one = '0;
    logic awready, wready, bvalid, arready, rvalid, req_in_valid, req_in_ready, req_in_last, alloc_tag_strobe;
    logic [1:0] bresp, rresp, req_in_dword_keep, rr;
    logic [31:0] rdata, rd;
    logic [63:0] req_in_data;
    logic [7:0] alloc_tag_out;
    rqh_side_t req_in_sideband;
    int err_count = 0, tests_run = 0, exp_tags = 0;
    always #25 aclk = ~aclk;
    rqh_requester_host dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .req_in_data, .req_in_valid, .req_in_ready, .req_in_last, .req_in_dword_keep, .req_in_sideband,
        .alloc_tag_out, .alloc_tag_strobe);
    rqh_dev_model dev (.aclk, .aresetn, .req_in_data, .req_in_valid, .req_in_ready, .req_in_last,
        .req_in_dword_keep, .req_in_sideband, .alloc_tag_out, .alloc_tag_strobe, .slow, .posted, .free_one);
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic hang();
        err_count++;
        stop_test();
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (n > 50) hang();
        end while (!bvalid);
        rr = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rdr(input logic [7:0] a);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'b0;
            if (n > 50) hang();
        end while (!rvalid);
        rd = rdata;
        rr = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic free_pulse();
        free_one <= 1'b1;
        @(posedge aclk);
        free_one <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic tag_chk();
        int n;
        n = 0;
        do begin
            rdr(ADDR_STATUS);
            n++;
            if (n > 40) hang();
        end while (rd[31:16] !== exp_tags[15:0]);
        chk(rd[15:8], exp_tags - 1);
    endtask
    task automatic cfg(input logic [31:0] len, input logic [31:0] m, input logic [31:0] ab);
        wr(ADDR_PAYLEN, len);
        wr(ADDR_MASKS, m);
        wr(ADDR_ABORT, ab);
    endtask
    task automatic go(input logic [5:0] c, input int beats, input logic np, input logic hold);
        int p, n;
        p = dev.npkt;
        n = 0;
        posted <= !np;
        wr(ADDR_CTRL, {26'h000_0000, c});
        while (dev.npkt != p + 1) begin
            @(posedge aclk);
            n++;
            if (n > 200) hang();
        end
        chk(dev.cap_n, beats);
        chk(dev.cap[0].data, {32'h0D00_0001, 32'h0D00_0000});
        chk(dev.cap[1].data, {32'h0D00_0003, 32'h0D00_0002});
        chk({dev.cap[0].keep, dev.cap[1].keep}, 4'hF);
        for (int i = 0; i < beats; i++) chk(dev.cap[i].last, i == beats - 1);
        chk(dev.hold_err, 0);
        if (np) begin
            exp_tags++;
            tag_chk();
            if (!hold) free_pulse();
        end
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        rdr(ADDR_STATUS);
        chk({rr, rd}, 0);
        rdr(8'h28);
        chk({rr, rd}, {RESP_SLVERR, 32'h0000_0000});
        wr(8'h2C, 32'h0000_0001);
        chk(rr, RESP_SLVERR);
        wr(ADDR_SEED, SEED_V);
        chk(rr, RESP_OKAY);
        rdr(ADDR_SEED);
        chk({rr, rd}, {RESP_OKAY, SEED_V});
        $display("register test done");
    endtask
    task automatic t_read();
        slow <= 1'b1;
        cfg(0, 32'h0000_053F, 0);
        go(6'h03, 2, 1, 0);
        chk(dev.cap_side[0], 12'h53F);
        go(6'h11, 2, 1, 0);
        chk(dev.cap_side[0][7:0], 8'h00);
        $display("read test done");
    endtask
    task automatic t_write();
        cfg(3, 32'h0000_0536, 0);
        go(6'h05, 4, 1, 0);
        chk({dev.cap[2].data, dev.cap[2].keep}, {SEED_V + 1, SEED_V, 2'b11});
        chk({dev.cap[3].data[31:0], dev.cap[3].keep}, {SEED_V + 2, 2'b01});
        chk(dev.cap_side[0][7:0], 8'h06);
        slow <= 1'b0;
        cfg(1, 32'h0000_0106, 0);
        go(6'h07, 3, 1, 0);
        chk({dev.cap[2].data[63:32], dev.cap_side[0]}, {SEED_V, 12'h106});
        $display("write test done");
    endtask
    task automatic t_msg_atom();
        cfg(2, 32'h0000_05FF, 0);
        go(6'h0B, 3, 0, 0);
        chk({dev.cap[2].data, dev.cap_side[0]}, {SEED_V + 1, SEED_V, 12'h000});
        cfg(2, 32'h0000_0012, 0);
        go(6'h0D, 3, 1, 0);
        chk({dev.cap[2].data, dev.cap_side[0][7:0]}, {SEED_V + 1, SEED_V, 8'hFF});
        $display("message and atomic test done");
    endtask
    task automatic t_abort();
        cfg(4, 32'h0000_0006, 1);
        go(6'h25, 4, 0, 0);
        chk({dev.cap[2].disc, dev.cap[3].disc, dev.nulled}, 3'b011);
        chk(dev.int_err, 1);
        $display("abort test done");
    endtask
    task automatic t_full();
        int p;
        cfg(0, 32'h0000_000F, 0);
        go(6'h01, 2, 1, 1);
        go(6'h01, 2, 1, 1);
        p = dev.npkt;
        posted <= 1'b0;
        wr(ADDR_CTRL, 32'h0000_0001);
        wr(ADDR_CTRL, 32'h0000_0001);
        rdr(ADDR_STATUS);
        chk({rd[0], req_in_valid, req_in_ready}, 3'b110);
        chk(dev.npkt, p);
        free_pulse();
        rdr(ADDR_STATUS);
        chk(dev.npkt, p + 1);
        exp_tags++;
        tag_chk();
        free_pulse();
        free_pulse();
        rdr(ADDR_STATUS);
        chk({rd[0], dev.npkt}, {1'b0, p + 1});
        $display("table full test done");
    endtask
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        for (int i = 0; i < 4; i++) wr(ADDR_DESC0 + 8'(4 * i), 32'h0D00_0000 + i);
        t_read();
        t_write();
        t_msg_atom();
        t_abort();
        t_full();
        stop_test();
    end
endmodule
`default_nettype wire
